// ---- verilog/lbs_pkg.sv ----
package lbs_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_NOMINAL   = 8'h04;
  localparam logic [7:0]  OFS_PCT_HI    = 8'h08;
  localparam logic [7:0]  OFS_PCT_LO    = 8'h0C;
  localparam logic [7:0]  OFS_BIN_CMD   = 8'h10;
  localparam logic [7:0]  OFS_SEC_LIMIT = 8'h14;
  localparam logic [7:0]  OFS_STATUS    = 8'h18;
  localparam logic [7:0]  OFS_MASK      = 8'h1C;
  localparam logic [7:0]  OFS_RESULT    = 8'h20;
  localparam logic [7:0]  OFS_VIEW_UP   = 8'h24;
  localparam logic [7:0]  OFS_VIEW_LO   = 8'h28;
  localparam logic [7:0]  OFS_OPEN      = 8'h2C;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_FULL_BIT    = 0;  // 1: one handler line per bin
  localparam int unsigned CTRL_SEC_MIN_BIT = 1;  // 1: secondary limit is a minimum
  localparam int unsigned CTRL_W           = 2;
  localparam logic [1:0]  CTRL_RST         = 2'h1;
  localparam int unsigned CMD_BIN_MSB      = 3;
  localparam int unsigned CMD_TWO_PCT_BIT  = 4;
  localparam int unsigned CMD_CLOSE_BIT    = 5;
  localparam int unsigned ST_DONE_BIT      = 0;
  localparam int unsigned ST_NOGO_BIT      = 1;
  localparam int unsigned ST_W             = 2;
  localparam logic [31:0] LIMIT_RST        = 32'h0000_0000;
  localparam logic [31:0] NOMINAL_RST      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // bins and percent scaling
  // ----------------------------------------------------------------
  localparam int unsigned NUM_REG_BINS  = 13;
  localparam int unsigned NUM_BINS      = 15;
  localparam logic [3:0]  BIN_SEC       = 4'h0;
  localparam logic [3:0]  BIN_FIRST     = 4'h1;
  localparam logic [3:0]  BIN_LAST_REG  = 4'hD;
  localparam logic [3:0]  BIN_REJECT    = 4'hE;
  localparam logic [3:0]  BIN_RED_LAST  = 4'h8;  // last go line in reduced mode
  localparam int unsigned PCT_W         = 16;    // signed, units of 0.01 %
  localparam int unsigned PCT_SCALE     = 10000;
  localparam int unsigned PROD_W        = 49;

  typedef struct packed {
    logic [31:0] principal_value;
    logic [31:0] secondary_param;
  } lbs_meas_t;

  typedef struct packed {
    logic       go;
    logic       nogo;
    logic [3:0] bin;
  } lbs_result_t;

endpackage : lbs_pkg

// ---- verilog/lbs_sorter.sv ----
`timescale 1ns/100ps

// How it works
// - Thirteen regular bins, one secondary reject bin, one other-reject bin: fifteen.
// - Bin zero holds the secondary limit; failing it gives bin zero; NO-GO is 0 or 14.
// - A passing part inside no open regular bin goes to bin fourteen.
// - Bin limits come from nominal plus percent; one percent gives a symmetric pair.
// - A value inside two open bins goes to the lower-numbered bin.
// - Reset clears the limits of bins zero through thirteen to zero.
// - Zero secondary limit fails all parts for maximum, passes all for minimum.
// - Regular bins start closed and accept nothing until limits are stored.
// - GO means secondary pass and landing in an open regular bin.
// - Full handler mode asserts only the line of the assigned bin.
// - Reduced mode has go lines 1..8; bins 9..13 show on the bin 14 line.
// - Nothing but a bin command alters stored limits; a nominal write leaves them.
// - Percent entries are converted to absolute limits before storing.
module lbs_sorter (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  input  wire logic [lbs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [lbs_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [lbs_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                      meas_valid,
  input  wire lbs_pkg::lbs_meas_t        meas,
  output logic                           go,
  output logic                           nogo,
  output logic      [3:0]                bin_num,
  output logic      [lbs_pkg::NUM_BINS-1:0] handler_lines,
  output logic                           irq
);
  import lbs_pkg::*;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [31:0]       nominal_reg, nominal_next;
  logic [PCT_W-1:0]  pct_hi_reg, pct_hi_next;
  logic [PCT_W-1:0]  pct_lo_reg, pct_lo_next;
  logic [31:0]       sec_lim_reg, sec_lim_next;
  logic [ST_W-1:0]   mask_reg, mask_next;
  logic [3:0]        view_reg, view_next;

  // simple writes; the nominal only moves on its own write
  always_comb begin
    ctrl_next    = ctrl_reg;
    nominal_next = nominal_reg;
    pct_hi_next  = pct_hi_reg;
    pct_lo_next  = pct_lo_reg;
    sec_lim_next = sec_lim_reg;
    mask_next    = mask_reg;
    view_next    = view_reg;
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL:      ctrl_next    = reg_wdata[CTRL_W-1:0];
        OFS_NOMINAL:   nominal_next = reg_wdata;
        OFS_PCT_HI:    pct_hi_next  = reg_wdata[PCT_W-1:0];
        OFS_PCT_LO:    pct_lo_next  = reg_wdata[PCT_W-1:0];
        OFS_SEC_LIMIT: sec_lim_next = reg_wdata;                 // bin zero limit
        OFS_MASK:      mask_next    = reg_wdata[ST_W-1:0];
        OFS_BIN_CMD:   view_next    = reg_wdata[CMD_BIN_MSB:0];
        default:       ctrl_next    = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg    <= CTRL_RST;
      nominal_reg <= NOMINAL_RST;
      pct_hi_reg  <= '0;
      pct_lo_reg  <= '0;
      sec_lim_reg <= LIMIT_RST;
      mask_reg    <= '0;
      view_reg    <= '0;
    end else begin
      ctrl_reg    <= ctrl_next;
      nominal_reg <= nominal_next;
      pct_hi_reg  <= pct_hi_next;
      pct_lo_reg  <= pct_lo_next;
      sec_lim_reg <= sec_lim_next;
      mask_reg    <= mask_next;
      view_reg    <= view_next;
    end
  end

  // ----------------------------------------------------------------
  // percent to absolute conversion
  // ----------------------------------------------------------------
  // truncation toward zero keeps a symmetric pair exactly symmetric;
  // percentages below -100 % wrap, software must not enter them
  logic signed [PROD_W-1:0] nom_s, pct_hi_s, pct_lo_s;
  logic signed [PROD_W-1:0] dv_hi, dv_lo, sum_hi, sum_lo;
  logic                     cmd_wr, cmd_two, cmd_close, cmd_reg_bin;
  logic [3:0]               cmd_bin;
  logic [31:0]              lim_hi, lim_lo;

  assign nom_s       = $signed({{(PROD_W-32){1'b0}}, nominal_reg});
  assign pct_hi_s    = $signed({{(PROD_W-PCT_W){pct_hi_reg[PCT_W-1]}}, pct_hi_reg});
  assign pct_lo_s    = $signed({{(PROD_W-PCT_W){pct_lo_reg[PCT_W-1]}}, pct_lo_reg});
  assign cmd_wr      = reg_wr && (reg_addr == OFS_BIN_CMD);
  assign cmd_bin     = reg_wdata[CMD_BIN_MSB:0];
  assign cmd_two     = reg_wdata[CMD_TWO_PCT_BIT];
  assign cmd_close   = reg_wdata[CMD_CLOSE_BIT];
  assign cmd_reg_bin = (cmd_bin >= BIN_FIRST) && (cmd_bin <= BIN_LAST_REG);
  assign dv_hi       = (nom_s * pct_hi_s) / $signed(PROD_W'(PCT_SCALE));
  // one percent mirrors the upper offset; two take the second as lower
  assign dv_lo       = cmd_two ? (nom_s * pct_lo_s) / $signed(PROD_W'(PCT_SCALE)) : -dv_hi;
  assign sum_hi      = nom_s + dv_hi;
  assign sum_lo      = nom_s + dv_lo;
  assign lim_hi      = sum_hi[31:0];
  assign lim_lo      = sum_lo[31:0];

  // ----------------------------------------------------------------
  // stored limits of the regular bins
  // ----------------------------------------------------------------
  logic [31:0]         upper_reg [NUM_REG_BINS:1];
  logic [31:0]         upper_next[NUM_REG_BINS:1];
  logic [31:0]         lower_reg [NUM_REG_BINS:1];
  logic [31:0]         lower_next[NUM_REG_BINS:1];
  logic [NUM_REG_BINS:1] open_reg, open_next;

  // only a bin command touches limits, so retuning the test leaves them
  always_comb begin
    upper_next = upper_reg;
    lower_next = lower_reg;
    open_next  = open_reg;
    if (cmd_wr && cmd_reg_bin) begin
      if (cmd_close) begin
        open_next[cmd_bin]  = 1'b0;
        upper_next[cmd_bin] = LIMIT_RST;
        lower_next[cmd_bin] = LIMIT_RST;
      end else begin
        open_next[cmd_bin]  = 1'b1;
        upper_next[cmd_bin] = lim_hi;
        lower_next[cmd_bin] = lim_lo;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      open_reg <= '0;
      for (int k = 1; k <= NUM_REG_BINS; k++) begin
        upper_reg[k] <= LIMIT_RST;
        lower_reg[k] <= LIMIT_RST;
      end
    end else begin
      open_reg   <= open_next;
      upper_reg  <= upper_next;
      lower_reg  <= lower_next;
    end
  end

  // ----------------------------------------------------------------
  // comparison and bin choice
  // ----------------------------------------------------------------
  logic [NUM_REG_BINS:1] hit;
  logic                  sec_pass, sort_en;
  lbs_result_t           res_reg, res_next;
  logic [NUM_BINS-1:0]   lines_reg, lines_next;

  // a closed bin never matches, whatever its stored limits
  genvar gi;
  generate
    for (gi = 1; gi <= NUM_REG_BINS; gi++) begin : g_cmp
      assign hit[gi] = open_reg[gi] &&
                       (meas.principal_value >= lower_reg[gi]) &&
                       (meas.principal_value <= upper_reg[gi]);
    end
  endgenerate

  // zero limit: max compare fails all, min compare passes all
  assign sec_pass = ctrl_reg[CTRL_SEC_MIN_BIT] ? (meas.secondary_param >= sec_lim_reg)
                                               : (meas.secondary_param <  sec_lim_reg);
  // a zero nominal switches sorting and GO/NO-GO off
  assign sort_en  = (nominal_reg != NOMINAL_RST);

  always_comb begin
    res_next   = res_reg;
    lines_next = lines_reg;
    if (meas_valid) begin
      res_next = '0;
      if (sort_en) begin
        if (!sec_pass) begin
          res_next.bin = BIN_SEC;
        end else begin
          res_next.bin = BIN_REJECT;
          // walk downward so the lowest matching bin wins
          for (int k = NUM_REG_BINS; k >= 1; k--) begin
            if (hit[k]) begin
              res_next.bin = 4'(k);
            end
          end
        end
        res_next.go   = (res_next.bin != BIN_SEC) && (res_next.bin != BIN_REJECT);
        res_next.nogo = !res_next.go;
      end
      lines_next = '0;
      if (sort_en) begin
        if (ctrl_reg[CTRL_FULL_BIT] || (res_next.bin <= BIN_RED_LAST)) begin
          lines_next[res_next.bin] = 1'b1;
        end else begin
          lines_next[BIN_REJECT] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      res_reg   <= '0;
      lines_reg <= '0;
    end else begin
      res_reg   <= res_next;
      lines_reg <= lines_next;
    end
  end

  // ----------------------------------------------------------------
  // status, interrupt and read data
  // ----------------------------------------------------------------
  logic [ST_W-1:0]   status_reg, status_next;
  logic              irq_reg, irq_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  // set wins over the clear-on-read so no event is lost
  always_comb begin
    status_next = status_reg;
    if (reg_rd && (reg_addr == OFS_STATUS)) begin
      status_next = '0;
    end
    if (meas_valid) begin
      status_next[ST_DONE_BIT] = 1'b1;
      if (res_next.nogo) begin
        status_next[ST_NOGO_BIT] = 1'b1;
      end
    end
    irq_next   = |(status_next & mask_next);
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL:      rdata_next = DATA_W'(ctrl_reg);
        OFS_NOMINAL:   rdata_next = nominal_reg;
        OFS_PCT_HI:    rdata_next = DATA_W'(pct_hi_reg);
        OFS_PCT_LO:    rdata_next = DATA_W'(pct_lo_reg);
        OFS_SEC_LIMIT: rdata_next = sec_lim_reg;
        OFS_STATUS:    rdata_next = DATA_W'(status_reg);
        OFS_MASK:      rdata_next = DATA_W'(mask_reg);
        OFS_RESULT:    rdata_next = DATA_W'(res_reg);
        OFS_VIEW_UP:   rdata_next = (view_reg >= BIN_FIRST && view_reg <= BIN_LAST_REG)
                                    ? upper_reg[view_reg] : sec_lim_reg;
        OFS_VIEW_LO:   rdata_next = (view_reg >= BIN_FIRST && view_reg <= BIN_LAST_REG)
                                    ? lower_reg[view_reg] : sec_lim_reg;
        OFS_OPEN:      rdata_next = DATA_W'({open_reg, 1'b0});
        default:       rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= '0;
      irq_reg    <= 1'b0;
      rdata_reg  <= '0;
    end else begin
      status_reg <= status_next;
      irq_reg    <= irq_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign go            = res_reg.go;
  assign nogo          = res_reg.nogo;
  assign bin_num       = res_reg.bin;
  assign handler_lines = lines_reg;
  assign irq           = irq_reg;
  assign reg_rdata     = rdata_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  result_hold_a: assert property (!meas_valid |=> $stable(res_reg) && $stable(lines_reg))
    else $error("result changed without a measurement");

  nogo_bins_a: assert property (nogo |-> (bin_num == BIN_SEC) || (bin_num == BIN_REJECT))
    else $error("no-go with a regular bin");

  go_range_a: assert property (go |-> bin_num >= BIN_FIRST && bin_num <= BIN_LAST_REG
                               && !nogo)
    else $error("go outside the regular bins");

  sec_fail_a: assert property (meas_valid && sort_en && !sec_pass
                               |=> bin_num == BIN_SEC && nogo)
    else $error("secondary failure not in bin zero");

  no_bin_a: assert property (meas_valid && sort_en && sec_pass && hit == '0
                             |=> bin_num == BIN_REJECT)
    else $error("unmatched part not in bin fourteen");

  lowest_bin_a: assert property (meas_valid && sort_en && sec_pass && hit[1]
                                 |=> bin_num == BIN_FIRST)
    else $error("overlap not given to lower bin");

  // checked at the result update: a mode change alone leaves older lines standing
  full_lines_a: assert property (meas_valid && sort_en && ctrl_reg[CTRL_FULL_BIT]
                                 |=> handler_lines == (NUM_BINS'(1) << bin_num))
    else $error("full handler lines not one-hot on bin");

  reduced_a: assert property (meas_valid && sort_en && !ctrl_reg[CTRL_FULL_BIT]
                              |=> bin_num > BIN_RED_LAST && bin_num < BIN_REJECT
                              |-> handler_lines == (NUM_BINS'(1) << BIN_REJECT))
    else $error("reduced mode bin not lumped with fourteen");

  sym_pair_a: assert property (cmd_wr && cmd_reg_bin && !cmd_close && !cmd_two
                               |=> upper_reg[$past(cmd_bin)] - nominal_reg
                                   == nominal_reg - lower_reg[$past(cmd_bin)])
    else $error("single percent pair not symmetric");

  irq_level_a: assert property (irq == |(status_reg & mask_reg))
    else $error("interrupt does not follow masked status");

endmodule : lbs_sorter

// ---- tb/lbs_handler.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------
// parts handler on the far side of the bin lines
// ----------------------------------------------------------------
module lbs_handler (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_b,
  input  wire logic [lbs_pkg::NUM_BINS-1:0] handler_lines,
  output logic      [3:0]                   part_bin,
  output logic                              multi_err
);
  import lbs_pkg::*;

  // lowest raised line picks the chute; no line leaves 4'hF
  always_comb begin
    part_bin = 4'hF;
    for (int i = NUM_BINS - 1; i >= 0; i--) begin
      if (handler_lines[i]) part_bin = 4'(i);
    end
  end

  // two lines at once would jam a real chute, so latch it as a fault
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) multi_err <= 1'b0;
    else if ($countones(handler_lines) > 1) multi_err <= 1'b1;
  end
endmodule : lbs_handler

// ---- tb/limit_bin_sorter_test.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------
// bench top: model of the sorter checked at every result
// ----------------------------------------------------------------
module limit_bin_sorter_test;
  import lbs_pkg::*;
  logic        sys_clk, rst_b, reg_wr, reg_rd, meas_valid, go, nogo, irq, multi_err;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0]  bin_num, part_bin;
  logic [14:0] handler_lines;
  lbs_meas_t   meas;
  int          err_count, cmp_count;
  // model state; limits kept wide so negative percents stay readable
  longint      up_m[15], lo_m[15], nom_m, sec_m;
  bit          opn_m[15];
  bit [1:0]    ctrl_m, msk_m, st_m;

  lbs_sorter dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meas_valid(meas_valid), .meas(meas), .go(go), .nogo(nogo), .bin_num(bin_num),
    .handler_lines(handler_lines), .irq(irq));
  lbs_handler hnd (.sys_clk(sys_clk), .rst_b(rst_b), .handler_lines(handler_lines),
    .part_bin(part_bin), .multi_err(multi_err));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // watchdog sized well above the few hundred cycles the tests need
  initial begin
    #200000;
    err_count++;
    stop_test();
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd_chk

  task automatic set_nom(input longint v);
    wr(OFS_NOMINAL, 32'(v));
    nom_m = v;
  endtask : set_nom

  task automatic set_ctrl(input bit [1:0] c);
    wr(OFS_CTRL, 32'(c));
    ctrl_m = c;
  endtask : set_ctrl

  // store or close one regular bin, then read back its absolute limits
  task automatic put_bin(input int b, input int hi, input int lo, input bit two, input bit cls);
    longint dh;
    logic [31:0] om;
    dh = (nom_m * hi) / 10000;
    om = '0;
    wr(OFS_PCT_HI, 32'(hi));
    if (two) wr(OFS_PCT_LO, 32'(lo));
    wr(OFS_BIN_CMD, 32'({cls, two, 4'(b)}));
    opn_m[b] = !cls;
    up_m[b]  = cls ? 0 : nom_m + dh;
    lo_m[b]  = cls ? 0 : (two ? nom_m + (nom_m * lo) / 10000 : nom_m - dh);
    for (int i = 1; i <= 13; i++) om[i] = opn_m[i];
    rd_chk(OFS_VIEW_UP, 32'(up_m[b]));
    rd_chk(OFS_VIEW_LO, 32'(lo_m[b]));
    rd_chk(OFS_OPEN, om);
  endtask : put_bin

  // one measurement; expectation built from the stored model limits
  task automatic part(input logic [31:0] p, input logic [31:0] s);
    int b;
    int hb;
    bit pass;
    bit g;
    bit ng;
    pass = ctrl_m[1] ? (longint'(s) >= sec_m) : (longint'(s) < sec_m);
    b = pass ? 14 : 0;
    for (int i = 13; i >= 1; i--) begin
      if (pass && opn_m[i] && longint'(p) >= lo_m[i] && longint'(p) <= up_m[i]) b = i;
    end
    hb = (ctrl_m[0] || b <= 8) ? b : 14;
    g  = b >= 1 && b <= 13;
    ng = b == 0 || b == 14;
    // zero nominal switches sorting and go/no-go off, no line raised
    if (nom_m == 0) begin
      b  = 0;
      hb = 15;
      g  = 1'b0;
      ng = 1'b0;
    end
    @(posedge sys_clk);
    meas_valid <= 1'b1;
    meas       <= '{principal_value: p, secondary_param: s};
    @(posedge sys_clk);
    meas_valid <= 1'b0;
    #1;
    st_m |= {ng, 1'b1};
    chk(go, g);
    chk(nogo, ng);
    chk(bin_num, b);
    chk(handler_lines, (g || ng) ? 32'(15'(1) << hb) : 32'h0);
    chk(part_bin, hb);
    chk(multi_err, 0);
    chk(irq, |(st_m & msk_m));
  endtask : part

  task automatic stop_test();
    $display("counts: compares=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    meas_valid = 1'b0;
    meas = '0;
    ctrl_m = CTRL_RST;
    void'($urandom(65635));
    repeat (20) @(posedge sys_clk);
    #1;
    chk({go, nogo, irq, handler_lines}, 0);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    rd_chk(OFS_CTRL, 32'(CTRL_RST));
    rd_chk(OFS_NOMINAL, NOMINAL_RST);
    rd_chk(OFS_SEC_LIMIT, LIMIT_RST);
    rd_chk(OFS_OPEN, 0);
    rd_chk(8'h3C, 0);
    $display("test reset done");
    // zero secondary limit: all fail as maximum, all pass as minimum
    set_nom(100000);
    part(100000, 0);
    set_ctrl(2'h3);
    part(100000, 0);
    $display("test zero limit done");
    // nested bins around nominals 100000 and 300000, bin 4 at 200000, overlap goes to the lower bin
    set_ctrl(2'h1);
    wr(OFS_SEC_LIMIT, 500);
    sec_m = 500;
    put_bin(1, 20, 0, 0, 0);
    put_bin(2, 100, 0, 0, 0);
    put_bin(3, 500, 0, 0, 0);
    set_nom(200000);
    put_bin(4, 200, -500, 1, 0);
    set_nom(300000);
    rd_chk(OFS_VIEW_UP, 32'(up_m[4]));
    rd_chk(OFS_VIEW_LO, 32'(lo_m[4]));
    put_bin(9, 100, 0, 0, 0);
    put_bin(13, 300, -200, 1, 0);
    part(100000, 10);
    part(100150, 10);
    part(204000, 10);
    rd_chk(OFS_RESULT, 32'h24);
    part(210000, 10);
    part(100000, 600);
    $display("test bins done");
    // random parts, alternating full and reduced handler wiring
    for (int n = 0; n < 60; n++) begin
      if (n % 15 == 0) set_ctrl({1'b0, ~ctrl_m[0]});
      part(90000 + $urandom_range(0, 220000), $urandom_range(0, 700));
    end
    $display("test random done");
    // closed bin takes nothing any more
    put_bin(1, 0, 0, 0, 1);
    part(100000, 10);
    // status read clears, mask gates the interrupt
    rd_chk(OFS_STATUS, 32'(st_m));
    st_m = 0;
    wr(OFS_MASK, 32'h2);
    msk_m = 2'h2;
    part(100000, 10);
    part(100000, 600);
    rd_chk(OFS_STATUS, 32'(st_m));
    st_m = 0;
    @(posedge sys_clk);
    #1;
    chk(irq, 0);
    $display("test status done");
    // second reset in mid-run clears limits; zero nominal turns sorting off
    rst_b <= 1'b0;
    @(posedge sys_clk);
    rst_b <= 1'b1;
    nom_m = 0;
    ctrl_m = CTRL_RST;
    sec_m = 0;
    msk_m = 0;
    st_m = 0;
    opn_m = '{default: 0};
    rd_chk(OFS_OPEN, 0);
    rd_chk(OFS_VIEW_UP, LIMIT_RST);
    part(100000, 10);
    $display("test second reset done");
    stop_test();
  end
endmodule : limit_bin_sorter_test
